// ===== scp_pkg.sv
// constants, enumerations and state records for the scan-port connect control
// assumes a primary test clock domain for the link and a 40 MHz system clock
package scp_pkg;

  localparam int          SCP_ADDR_W       = 10;
  localparam int          SCP_DATA_PAIRS   = 10;
  localparam int          SCP_ACK_BITS     = 28;
  localparam logic [9:0]  SCP_RESET_ADDR   = 10'h000;
  localparam logic [9:0]  SCP_DISC_ADDR    = 10'h3FE;
  localparam logic [9:0]  SCP_SYNC_ADDR    = 10'h3FF;
  localparam logic [4:0]  SCP_PAIRS_FULL   = 5'h0A;
  localparam logic [4:0]  SCP_CNT_MAX      = 5'h1F;
  localparam logic [4:0]  SCP_ACK_LAST     = 5'h1B;

  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0,
    TAP_IDLE     = 4'h1,
    TAP_SEL_DR   = 4'h2,
    TAP_CAP_DR   = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR   = 4'h8,
    TAP_SEL_IR   = 4'h9,
    TAP_CAP_IR   = 4'hA,
    TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC,
    TAP_PAUSE_IR = 4'hD,
    TAP_EXIT2_IR = 4'hE,
    TAP_UPD_IR   = 4'hF
  } scp_tap_e;

  typedef enum logic [2:0] {
    RX_HUNT  = 3'h0,
    RX_SEL2  = 3'h1,
    RX_PAIR1 = 3'h2,
    RX_PAIR2 = 3'h3,
    RX_TAIL1 = 3'h4,
    RX_TAIL2 = 3'h5
  } scp_rx_e;

  typedef enum logic [1:0] {
    ST_OFF   = 2'h0,
    ST_ON    = 2'h1,
    ST_RESET = 2'h2,
    ST_MCAST = 2'h3
  } scp_status_e;

  typedef struct packed {
    scp_tap_e tap;
  } scp_tap_s;

  typedef struct packed {
    logic [9:0]  addrSync1;
    logic [9:0]  boardAddr;
    scp_rx_e     rxState;
    logic [1:0]  hist;
    logic        firstBit;
    logic [4:0]  dataCnt;
    logic        allOnes;
    logic        allZeros;
    logic [9:0]  rxAddr;
    scp_tap_e    startTap;
    logic        ackActive;
    logic [4:0]  ackCnt;
    scp_status_e status;
    logic        statusToggle;
    logic        priOut;
    logic        priOe;
    logic        secOut;
    logic        secOe;
    logic        secModeSel;
  } scp_link_s;

  typedef struct packed {
    logic        togSync1;
    logic        togSync2;
    logic        togSeen;
    scp_status_e status;
    logic        updated;
  } scp_sys_s;

  localparam scp_tap_s SCP_TAP_RESET = '{tap: TAP_RESET};

  localparam scp_link_s SCP_LINK_RESET = '{
    addrSync1: 10'h000, boardAddr: 10'h000, rxState: RX_HUNT, hist: 2'h0,
    firstBit: 1'b0, dataCnt: 5'h00, allOnes: 1'b0, allZeros: 1'b0,
    rxAddr: 10'h000, startTap: TAP_RESET, ackActive: 1'b0, ackCnt: 5'h00,
    status: ST_OFF, statusToggle: 1'b0, priOut: 1'b1, priOe: 1'b0,
    secOut: 1'b1, secOe: 1'b0, secModeSel: 1'b1};

  localparam scp_sys_s SCP_SYS_RESET = '{
    togSync1: 1'b0, togSync2: 1'b0, togSeen: 1'b0, status: ST_OFF, updated: 1'b0};

endpackage

// ===== scp_tap_monitor.sv
// mirror of the primary test access port controller
// assumes mode select is sampled in the primary test clock domain
`timescale 1ns/1ps
`default_nettype none
module scp_tap_monitor
  import scp_pkg::*;
(
  // link clock and reset
  input  wire logic  primaryTestClock,
  input  wire logic  linkRst_n,
  // mode select and monitored state
  input  wire logic  primaryModeSelect,
  output scp_tap_e   tapState
);

  scp_tap_s tapReg;
  scp_tap_s tapNext;

  always_comb
  begin
    tapNext = tapReg;
    case (tapReg.tap)
      TAP_RESET:    tapNext.tap = primaryModeSelect ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tapNext.tap = primaryModeSelect ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tapNext.tap = primaryModeSelect ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tapNext.tap = primaryModeSelect ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tapNext.tap = primaryModeSelect ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tapNext.tap = primaryModeSelect ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tapNext.tap = primaryModeSelect ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tapNext.tap = primaryModeSelect ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tapNext.tap = primaryModeSelect ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tapNext.tap = primaryModeSelect ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tapNext.tap = primaryModeSelect ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tapNext.tap = primaryModeSelect ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tapNext.tap = primaryModeSelect ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tapNext.tap = primaryModeSelect ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tapNext.tap = primaryModeSelect ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tapNext.tap = primaryModeSelect ? TAP_SEL_DR   : TAP_IDLE;
      default:      tapNext.tap = TAP_RESET;
    endcase
  end

  always_ff @(posedge primaryTestClock or negedge linkRst_n)
  begin
    if (!linkRst_n)
      tapReg <= SCP_TAP_RESET;
    else
      tapReg <= tapNext;
  end

  assign tapState = tapReg.tap;

endmodule
`default_nettype wire

// ===== scp_connect_control.sv
// connect control of a multidrop addressable scan switch: state monitor,
// select reception, address matching, acknowledge and secondary port drive
// assumes serial and mode-select pins are synchronous to primaryTestClock;
// board address pins are static straps; clk is the 40 MHz system clock
//
// Overview of operation
// - state monitor follows mode select each edge
// - power-up or test reset forces Test-Logic-Reset
// - protocols only in reset, idle, both pauses
// - other states neither accept nor answer protocols
// - no sync address in reset or idle
// - pause states accept and recognise sync address
// - status from last address comparison, or OFF if a protocol breaks after data begins
// - decode reset, disconnect, sync, own address, else no-match
// - matching address: acknowledge first, then ON
// - non-matching address: OFF at once, no acknowledge
// - pairs: idle 11, select 00, one 01, zero 10
// - ten data pairs framed, first pair lsb
// - reset address: RESET, mode select forced high
// - sync address: MULTICAST, primary out released
`timescale 1ns/1ps
`default_nettype none
module scp_connect_control
  import scp_pkg::*;
(
  // system clock domain
  input  wire logic        clk,
  input  wire logic        reset_n,
  output scp_status_e      connectStatus,
  output logic             statusUpdated,
  // primary port
  input  wire logic        primaryTestClock,
  input  wire logic        primaryTestReset_n,
  input  wire logic        primaryModeSelect,
  input  wire logic        primarySerialIn,
  output logic             primarySerialOut,
  output logic             primarySerialOutOe,
  // secondary port
  input  wire logic        secondarySerialIn,
  output logic             secondarySerialOut,
  output logic             secondarySerialOutOe,
  output logic             secondaryModeSelect,
  // board address straps
  input  wire logic [9:0]  boardAddressInputs
);

  logic        linkRst_n;
  scp_tap_e    tapState;
  scp_link_s   lnkReg;
  scp_link_s   lnkNext;
  scp_sys_s    sysReg;
  scp_sys_s    sysNext;

  // either reset clears the link side without a clock edge
  assign linkRst_n = reset_n & primaryTestReset_n;

  scp_tap_monitor u_tap_monitor (
    .primaryTestClock  (primaryTestClock),
    .linkRst_n         (linkRst_n),
    .primaryModeSelect (primaryModeSelect),
    .tapState          (tapState)
  );

  // acknowledge frame, index 0 leaves first: I S ten data pairs S I
  function automatic logic [SCP_ACK_BITS-1:0] ackFrame(input logic [9:0] addr);
    logic [SCP_ACK_BITS-1:0] f;
    f = 28'h000_0000;
    f[1:0] = 2'b11;
    f[27:26] = 2'b11;
    for (int i = 0; i < SCP_DATA_PAIRS; i++)
    begin
      f[4 + 2 * i] = ~addr[i];
      f[5 + 2 * i] = addr[i];
    end
    return f;
  endfunction

  logic                     stableOk;
  logic                     pauseOk;
  logic                     setStatus;
  scp_status_e              newStatus;
  logic [SCP_ACK_BITS-1:0]  frame;

  always_comb
  begin
    lnkNext = lnkReg;
    setStatus = 1'b0;
    newStatus = lnkReg.status;
    frame = ackFrame(lnkReg.rxAddr);
    lnkNext.addrSync1 = boardAddressInputs;
    lnkNext.boardAddr = lnkReg.addrSync1;
    lnkNext.hist = {lnkReg.hist[0], primarySerialIn};
    stableOk = (tapState == TAP_RESET) || (tapState == TAP_IDLE) ||
               (tapState == TAP_PAUSE_DR) || (tapState == TAP_PAUSE_IR);
    pauseOk = (tapState == TAP_PAUSE_DR) || (tapState == TAP_PAUSE_IR);
    if (lnkReg.ackActive)
    begin
      if (!stableOk || (tapState != lnkReg.startTap))
      begin
        // state change mid-acknowledge dissolves the connection
        lnkNext.ackActive = 1'b0;
        setStatus = 1'b1;
        newStatus = ST_OFF;
      end
      else if (lnkReg.ackCnt == SCP_ACK_LAST)
      begin
        lnkNext.ackActive = 1'b0;
        setStatus = 1'b1;
        newStatus = ST_ON;
      end
      else
        lnkNext.ackCnt = lnkReg.ackCnt + 5'h01;
    end
    else if ((lnkReg.rxState != RX_HUNT) &&
             (!stableOk || (tapState != lnkReg.startTap)))
    begin
      lnkNext.rxState = RX_HUNT;
      if (lnkReg.dataCnt != 5'h00)
      begin
        setStatus = 1'b1;
        newStatus = ST_OFF;
      end
    end
    else if (stableOk)
    begin
      case (lnkReg.rxState)
        RX_HUNT:
          if (!primarySerialIn && (lnkReg.hist == 2'b11))
          begin
            lnkNext.rxState = RX_SEL2;
            lnkNext.startTap = tapState;
            lnkNext.dataCnt = 5'h00;
            lnkNext.allOnes = 1'b1;
            lnkNext.allZeros = 1'b1;
            lnkNext.rxAddr = 10'h000;
          end
        RX_SEL2:
          lnkNext.rxState = primarySerialIn ? RX_HUNT : RX_PAIR1;
        RX_PAIR1:
        begin
          lnkNext.firstBit = primarySerialIn;
          lnkNext.rxState = RX_PAIR2;
        end
        RX_PAIR2:
          case ({lnkReg.firstBit, primarySerialIn})
            2'b01, 2'b10:
            begin
              if (lnkReg.dataCnt < SCP_PAIRS_FULL)
                lnkNext.rxAddr[lnkReg.dataCnt[3:0]] = primarySerialIn;
              if (primarySerialIn)
                lnkNext.allZeros = 1'b0;
              else
                lnkNext.allOnes = 1'b0;
              if (lnkReg.dataCnt != SCP_CNT_MAX)
                lnkNext.dataCnt = lnkReg.dataCnt + 5'h01;
              lnkNext.rxState = RX_PAIR1;
            end
            2'b00:
              lnkNext.rxState = (lnkReg.dataCnt == 5'h00) ? RX_HUNT : RX_TAIL1;
            default:
            begin
              lnkNext.rxState = RX_HUNT;
              if (lnkReg.dataCnt != 5'h00)
              begin
                setStatus = 1'b1;
                newStatus = ST_OFF;
              end
            end
          endcase
        RX_TAIL1:
          if (primarySerialIn)
            lnkNext.rxState = RX_TAIL2;
          else
          begin
            lnkNext.rxState = RX_HUNT;
            setStatus = 1'b1;
            newStatus = ST_OFF;
          end
        RX_TAIL2:
        begin
          lnkNext.rxState = RX_HUNT;
          setStatus = 1'b1;
          newStatus = ST_OFF;
          if (!primarySerialIn || (lnkReg.dataCnt < SCP_PAIRS_FULL))
            newStatus = ST_OFF;
          else if (lnkReg.dataCnt != SCP_PAIRS_FULL)
          begin
            // over-long runs of one value still name a global address
            if (lnkReg.allZeros)
              newStatus = ST_RESET;
            else if (lnkReg.allOnes && pauseOk)
              newStatus = ST_MCAST;
          end
          else if (lnkReg.rxAddr == SCP_RESET_ADDR)
            newStatus = ST_RESET;
          else if (lnkReg.rxAddr == SCP_DISC_ADDR)
            newStatus = ST_OFF;
          else if (lnkReg.rxAddr == SCP_SYNC_ADDR)
            newStatus = pauseOk ? ST_MCAST : ST_OFF;
          else if (lnkReg.rxAddr == lnkReg.boardAddr)
          begin
            lnkNext.ackActive = 1'b1;
            lnkNext.ackCnt = 5'h00;
          end
        end
        default:
          lnkNext.rxState = RX_HUNT;
      endcase
    end
    if (setStatus)
    begin
      lnkNext.status = newStatus;
      lnkNext.statusToggle = ~lnkReg.statusToggle;
    end
    lnkNext.priOe = lnkNext.ackActive || (lnkNext.status == ST_ON);
    lnkNext.priOut = lnkNext.ackActive ? frame[lnkNext.ackCnt] : secondarySerialIn;
    lnkNext.secOe = (lnkNext.status == ST_ON) || (lnkNext.status == ST_MCAST);
    lnkNext.secOut = primarySerialIn;
    case (lnkNext.status)
      ST_ON, ST_MCAST: lnkNext.secModeSel = primaryModeSelect;
      ST_RESET:        lnkNext.secModeSel = 1'b1;
      default:         lnkNext.secModeSel = lnkReg.secModeSel;
    endcase
  end

  always_ff @(posedge primaryTestClock or negedge linkRst_n)
  begin
    if (!linkRst_n)
      lnkReg <= SCP_LINK_RESET;
    else
      lnkReg <= lnkNext;
  end

  assign primarySerialOut = lnkReg.priOut;
  assign primarySerialOutOe = lnkReg.priOe;
  assign secondarySerialOut = lnkReg.secOut;
  assign secondarySerialOutOe = lnkReg.secOe;
  assign secondaryModeSelect = lnkReg.secModeSel;

  // status word crosses by toggle; a protocol lasts far longer than the
  // three system cycles the capture needs, so the word is stable when read
  always_comb
  begin
    sysNext = sysReg;
    sysNext.togSync1 = lnkReg.statusToggle;
    sysNext.togSync2 = sysReg.togSync1;
    sysNext.togSeen = sysReg.togSync2;
    sysNext.updated = sysReg.togSync2 ^ sysReg.togSeen;
    if (sysReg.togSync2 ^ sysReg.togSeen)
      sysNext.status = lnkReg.status;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sysReg <= SCP_SYS_RESET;
    else
      sysReg <= sysNext;
  end

  assign connectStatus = sysReg.status;
  assign statusUpdated = sysReg.updated;

endmodule
`default_nettype wire

// ===== scp_connect_control_asserts.sv
// port assertions for the scan-port connect control
// assumes it is bound into scp_connect_control; link clock stops between frames
`timescale 1ns/1ps
`default_nettype none
module scp_connect_control_asserts
  import scp_pkg::*;
(
  // clocks and resets
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        primaryTestClock,
  input wire logic        primaryTestReset_n,
  // primary port
  input wire logic        primaryModeSelect,
  input wire logic        primarySerialIn,
  input wire logic        primarySerialOut,
  input wire logic        primarySerialOutOe,
  // secondary port
  input wire logic        secondarySerialIn,
  input wire logic        secondarySerialOut,
  input wire logic        secondarySerialOutOe,
  input wire logic        secondaryModeSelect,
  // status
  input wire scp_status_e connectStatus,
  input wire logic        statusUpdated
);
  wire logic linkDown = !reset_n || !primaryTestReset_n;

  chk_sec_follow: assert property (@(posedge primaryTestClock)
    disable iff (linkDown) secondarySerialOutOe && $past(secondarySerialOutOe)
    |-> secondarySerialOut == $past(primarySerialIn)) else $error("sec out lag");
  chk_pri_return: assert property (@(posedge primaryTestClock)
    disable iff (linkDown) primarySerialOutOe && secondarySerialOutOe
    && $past(primarySerialOutOe && secondarySerialOutOe)
    |-> primarySerialOut == $past(secondarySerialIn)) else $error("pri out lag");
  chk_mode_follow: assert property (@(posedge primaryTestClock)
    disable iff (linkDown) secondarySerialOutOe && $past(secondarySerialOutOe)
    |-> secondaryModeSelect == $past(primaryModeSelect)) else $error("mode lag");
  chk_mode_hold: assert property (@(posedge primaryTestClock)
    disable iff (linkDown) !secondarySerialOutOe && !$past(secondarySerialOutOe)
    |-> !$fell(secondaryModeSelect)) else $error("mode fell while off");
  chk_ack_frame: assert property (@(posedge primaryTestClock)
    disable iff (linkDown) $rose(primarySerialOutOe) && !secondarySerialOutOe
    |-> primarySerialOut ##1 primarySerialOut ##1 !primarySerialOut ##1 !primarySerialOut)
    else $error("ack framing");
  chk_ack_then_on: assert property (@(posedge primaryTestClock)
    disable iff (linkDown) $rose(primarySerialOutOe) && !secondarySerialOutOe
    |-> ##27 !secondarySerialOutOe ##1 secondarySerialOutOe) else $error("on timing");
  chk_trst_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !primaryTestReset_n |-> !primarySerialOutOe && !secondarySerialOutOe
    && secondaryModeSelect) else $error("drive in link reset");
  chk_pulse_one: assert property (@(posedge clk) disable iff (!reset_n)
    statusUpdated |=> !statusUpdated) else $error("long update pulse");
  chk_status_flag: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(connectStatus) |-> statusUpdated || $past(statusUpdated))
    else $error("silent status change");

  cover property (@(posedge clk) connectStatus == ST_ON);
  cover property (@(posedge clk) connectStatus == ST_MCAST);
  cover property (@(posedge clk) connectStatus == ST_RESET);
endmodule

bind scp_connect_control scp_connect_control_asserts u_chk (.clk, .reset_n,
  .primaryTestClock, .primaryTestReset_n, .primaryModeSelect, .primarySerialIn,
  .primarySerialOut, .primarySerialOutOe, .secondarySerialIn, .secondarySerialOut,
  .secondarySerialOutOe, .secondaryModeSelect, .connectStatus, .statusUpdated);
`default_nettype wire

// ===== scp_master_model.sv
// test bus master on the primary scan port: tap moves and select frames
// assumes the bench resolves the primary out pin, pulled high, into heardPin
`timescale 1ns/1ps
`default_nettype none
module scp_master_model (
  // primary port drive
  output logic     primaryTestClock,
  output logic     primaryTestReset_n,
  output logic     primaryModeSelect,
  output logic     primarySerialIn,
  // resolved primary out
  input wire logic heardPin
);
  logic [27:0] heard;
  initial
  begin
    primaryTestClock = 1'b0;
    primaryTestReset_n = 1'b1;
    primaryModeSelect = 1'b1;
    primarySerialIn = 1'b1;
  end
  // clock runs only inside a step, so it stands still between frames
  task automatic step(input logic ms, input logic di);
    primaryModeSelect <= ms;
    primarySerialIn <= di;
    #1 heard = {heardPin, heard[27:1]};
    #2 primaryTestClock = 1'b1;
    #3 primaryTestClock = 1'b0;
  endtask
  task automatic nav(input logic [15:0] seq, input int n);
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b1);
  endtask
  task automatic pair(input logic ms, input logic [1:0] p);
    step(ms, p[1]);
    step(ms, p[0]);
  endtask
  task automatic sendSelect(input logic ms, input logic [9:0] a);
    pair(ms, 2'h3);
    pair(ms, 2'h0);
    for (int i = 0; i < 10; i++)
      pair(ms, a[i] ? 2'h1 : 2'h2);
    pair(ms, 2'h0);
    pair(ms, 2'h3);
  endtask
  // data line left idle high while the answer comes back; the answer starts
  // on the closing idle edge, so 28 samples taken before each edge hold it
  task automatic listen(input logic ms);
    for (int i = 0; i < 28; i++)
      step(ms, 1'b1);
  endtask
  task automatic hold(input logic v);
    primaryTestReset_n <= v;
    #30;
  endtask
endmodule
`default_nettype wire

// ===== scp_connect_control_tb.sv
// self-checking bench for the scan-port connect control
// assumes the master model owns the link clock and primary inputs
`timescale 1ns/1ps
`default_nettype none
module scp_connect_control_tb
  import scp_pkg::*;
;
  localparam logic [9:0] STRAP = 10'h2A5;
  logic        clk, reset_n, tck, tRst_n, pMs, pIn, pOut, pOe, sIn, sOut, sOe, sMs, upd;
  scp_status_e cStat;
  int          failures = 0;
  int          nChecks = 0;
  int          cycles = 0;
  wire logic   heardPin = pOe ? pOut : 1'b1;

  scp_connect_control dut (.clk, .reset_n, .connectStatus(cStat), .statusUpdated(upd),
    .primaryTestClock(tck), .primaryTestReset_n(tRst_n), .primaryModeSelect(pMs),
    .primarySerialIn(pIn), .primarySerialOut(pOut), .primarySerialOutOe(pOe),
    .secondarySerialIn(sIn), .secondarySerialOut(sOut), .secondarySerialOutOe(sOe),
    .secondaryModeSelect(sMs), .boardAddressInputs(STRAP));
  scp_master_model m (.primaryTestClock(tck), .primaryTestReset_n(tRst_n),
    .primaryModeSelect(pMs), .primarySerialIn(pIn), .heardPin);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      conclude();
    end
  end

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d failures=%0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [27:0] ackFrame(input logic [9:0] a);
    logic [27:0] f;
    f = 28'hC00_0003;
    for (int i = 0; i < 10; i++)
      f[4+2*i +: 2] = {a[i], ~a[i]};
    return f;
  endfunction
  // mode 0 idle, 1 pause-dr, 2 test-logic-reset, 3 pause-ir
  task automatic doSelect(input int mode, input logic [9:0] a, input scp_status_e exp);
    logic ms;
    ms = (mode == 2);
    case (mode)
      0: m.nav(16'h001F, 6);
      1: m.nav(16'h015F, 10);
      2: m.nav(16'h001F, 5);
      default: m.nav(16'h02DF, 11);
    endcase
    m.sendSelect(ms, a);
    m.listen(ms);
    check(m.heard, exp == ST_ON ? ackFrame(a) : 28'hFFF_FFFF);
    repeat (8) @(posedge clk);
    check(cStat, exp);
    check({pOe, sOe}, exp == ST_ON ? 2'h3 : {1'b0, exp == ST_MCAST});
    if (exp == ST_RESET)
      check(sMs, 1'b1);
  endtask
  task automatic scnTable();
    int          md [11] = '{0, 0, 0, 0, 0, 2, 0, 1, 3, 3, 1};
    logic [9:0]  ad [11] = '{STRAP, SCP_DISC_ADDR, STRAP, 10'h155, SCP_RESET_ADDR,
      SCP_SYNC_ADDR, SCP_SYNC_ADDR, SCP_SYNC_ADDR, SCP_DISC_ADDR, SCP_SYNC_ADDR, STRAP};
    scp_status_e st [11] = '{ST_ON, ST_OFF, ST_ON, ST_OFF, ST_RESET, ST_OFF, ST_OFF,
      ST_MCAST, ST_OFF, ST_MCAST, ST_ON};
    for (int i = 0; i < 11; i++)
      doSelect(md[i], ad[i], st[i]);
  endtask
  task automatic scnOnLinks();
    sIn <= 1'b0;
    m.step(1'b0, 1'b0);
    m.step(1'b0, 1'b0);
    check({sOut, heardPin}, 2'h0);
    sIn <= 1'b1;
    m.step(1'b0, 1'b1);
    m.step(1'b0, 1'b1);
    check({sOut, heardPin}, 2'h3);
  endtask
  task automatic scnShift();
    m.nav(16'h005F, 9);
    m.sendSelect(1'b0, SCP_DISC_ADDR);
    m.listen(1'b0);
    repeat (8) @(posedge clk);
    check(cStat, ST_ON);
    check({pOe, sOe}, 2'h3);
  endtask
  // a monitor left outside test-logic-reset would miss pause on this path
  task automatic scnLinkReset();
    m.hold(1'b0);
    check({pOe, sOe, sMs}, 3'h1);
    m.hold(1'b1);
    m.nav(16'h000A, 5);
    m.sendSelect(1'b0, SCP_SYNC_ADDR);
    m.listen(1'b0);
    repeat (8) @(posedge clk);
    check(cStat, ST_MCAST);
  endtask

  initial
  begin
    reset_n = 1'b0;
    sIn = 1'b1;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    scnTable();
    scnOnLinks();
    scnShift();
    scnLinkReset();
    conclude();
  end
endmodule
`default_nettype wire
